// >>> src/fbc_consts.vh
// Constants of the flash bus command interface
`ifndef FBC_CONSTS_VH
`define FBC_CONSTS_VH
`define FBC_CMD_READ_ARRAY  8'hFF
`define FBC_CMD_READ_ID     8'h90
`define FBC_CMD_READ_STATUS 8'h70
`define FBC_CMD_CLEAR_STAT  8'h50
`define FBC_CMD_ERASE_SETUP 8'h20
`define FBC_CMD_CONFIRM     8'hD0
`define FBC_CMD_PROG_SETUP  8'h40
`define FBC_CMD_PROG_ALT    8'h10
`define FBC_CMD_SUSPEND     8'hB0
`define FBC_CMD_CONFIG_SET  8'h60
`define FBC_CMD_CONFIG_CONF 8'h03
`define FBC_STATUS_RESET    8'h80
`define FBC_CFG_RESET       6'h00
`define FBC_SR_READY        7
`define FBC_SR_ERASE_SUSP   6
`define FBC_SR_ERASE_ERR    5
`define FBC_SR_PROG_ERR     4
`define FBC_SR_VPP_ERR      3
`define FBC_SR_PROG_SUSP    2
`define FBC_SR_PROTECT_ERR  1
`define FBC_CFG_SYNC_BIT    5
`define FBC_CFG_LEN_LSB     0
`define FBC_CFG_LEN_MSB     1
`define FBC_ID_MFR_ADDR     2'h0
`define FBC_ID_DEV_ADDR     2'h1
`define FBC_ID_CFG_ADDR     2'h2
`define FBC_PAGE_BITS       2
`endif

// >>> src/fbc_addr_latch.v
// Address latch: opens with addr_valid_n and chipSelectN low, reloads on each clock edge until latchOpen falls
`timescale 1ns/1ps
module fbc_addr_latch #(
    parameter AW = 20
) (
    // Clock and reset
    input  wire          clock,
    input  wire          srst,
    // Strobes
    input  wire          latchOpen,
    input  wire          closeNow,
    input  wire [AW-1:0] addrIn,
    // Latched address
    output reg  [AW-1:0] addrOut,
    output reg           captured
);
    always @(posedge clock) begin
        if (srst) begin
            addrOut  <= {AW{1'b0}};
            captured <= 1'b0;
        end else begin
            captured <= 1'b0;
            if (latchOpen) begin
                addrOut <= addrIn;
                if (closeNow) begin
                    captured <= 1'b1;
                end
            end
        end
    end
endmodule

// >>> src/fbc_write_engine.v
// Write engine model: erase and program timing, suspend, error flags
`timescale 1ns/1ps
`include "fbc_consts.vh"
module fbc_write_engine #(
    parameter ERASE_CYCLES = 64,
    parameter PROG_CYCLES  = 16
) (
    // Clock and reset
    input  wire       clock,
    input  wire       srst,
    // Commands from decoder
    input  wire       startErase,
    input  wire       startProg,
    input  wire       clearErr,
    input  wire       suspendReq,
    input  wire       resumeReq,
    input  wire       lockedBlock,
    input  wire       vppLow,
    // State
    output wire       busy,
    output reg        eraseSusp,
    output reg        progSusp,
    output reg        eraseErr,
    output reg        progErr,
    output reg        vppErr,
    output reg        protectErr
);
    reg [15:0] count;
    reg        running;
    reg        isErase;
    assign busy = running & ~eraseSusp & ~progSusp;

    always @(posedge clock) begin
        if (srst) begin
            count      <= 16'h0000;
            running    <= 1'b0;
            isErase    <= 1'b0;
            eraseSusp  <= 1'b0;
            progSusp   <= 1'b0;
            eraseErr   <= 1'b0;
            progErr    <= 1'b0;
            vppErr     <= 1'b0;
            protectErr <= 1'b0;
        end else begin
            // Clear first so that a same-cycle error set wins
            if (clearErr) begin
                eraseErr   <= 1'b0;
                progErr    <= 1'b0;
                vppErr     <= 1'b0;
                protectErr <= 1'b0;
            end
            // Erase setup not followed by its confirm flags both errors
            if (startErase && startProg) begin
                eraseErr <= 1'b1;
                progErr  <= 1'b1;
            end else if (!running && (startErase || startProg)) begin
                if (lockedBlock || vppLow) begin
                    protectErr <= protectErr | lockedBlock;
                    vppErr     <= vppErr | vppLow;
                    eraseErr   <= eraseErr | startErase;
                    progErr    <= progErr | startProg;
                end else begin
                    running <= 1'b1;
                    isErase <= startErase;
                    count   <= startErase ? ERASE_CYCLES[15:0]
                                          : PROG_CYCLES[15:0];
                end
            end else if (running) begin
                if (suspendReq && busy) begin
                    eraseSusp <= isErase;
                    progSusp  <= ~isErase;
                end else if (resumeReq) begin
                    eraseSusp <= 1'b0;
                    progSusp  <= 1'b0;
                end else if (busy) begin
                    if (count == 16'h0001) begin
                        running <= 1'b0;
                    end
                    count <= count - 16'h0001;
                end
            end
        end
    end
endmodule

// >>> src/fbc_command_decoder.v
// Flash bus interface and command decoder top
`timescale 1ns/1ps
`include "fbc_consts.vh"
module fbc_command_decoder #(
    parameter AW           = 20,
    parameter DW           = 16,
    parameter PARAM_TOP    = 20'h0_8000,
    parameter LOCK_TOP     = 20'h0_8000,
    parameter ERASE_CYCLES = 64,
    parameter PROG_CYCLES  = 16,
    parameter MFR_CODE     = 16'h5A5A, // Arbitrary value
    parameter DEV_CODE     = 16'hA5A5  // Arbitrary value
) (
    // Clock and reset
    input  wire          clock,
    input  wire          srst,
    // Flash bus strobes
    input  wire          powerdown_reset_n,
    input  wire          chipSelectN,
    input  wire          addr_valid_n,
    input  wire          outputEnableN,
    input  wire          writeEnableN,
    input  wire          writeProtectN,
    input  wire          vppLow,
    input  wire [AW-1:0] address,
    // Data lines, split
    input  wire [DW-1:0] dataLinesIn,
    output reg  [DW-1:0] data_lines,
    output reg           dataLinesOe,
    // Array access toward storage
    input  wire [DW-1:0] arrayData,
    output reg  [AW-1:0] arrayAddr,
    output reg           progStrobe,
    output reg  [AW-1:0] program_address,
    output reg  [DW-1:0] program_data,
    output reg           eraseStrobe,
    output reg  [7:0]    status_read_data
);
    localparam M_ARRAY  = 3'b001;
    localparam M_ID     = 3'b010;
    localparam M_STATUS = 3'b100;
    localparam P_IDLE   = 4'b0001;
    localparam P_ERASE  = 4'b0010;
    localparam P_PROG   = 4'b0100;
    localparam P_CFG    = 4'b1000;

    reg  [2:0]    readMode;
    reg  [3:0]    pend;
    reg  [5:0]    read_config_value;
    reg           ceQ;
    reg           weQ;
    reg           advQ;
    reg  [AW-1:0] wrAddr;
    reg  [AW-1:0] burstAddr;
    wire          inReset = srst | ~powerdown_reset_n;
    wire [AW-1:0] latchedAddr;
    wire          addrCaptured;
    wire          busy;
    wire          eraseSusp;
    wire          progSusp;
    wire          eraseErr;
    wire          progErr;
    wire          vppErr;
    wire          protectErr;
    reg           startErase;
    reg           startProg;
    reg           suspendReq;
    reg           resumeReq;
    wire [7:0]    cmd = dataLinesIn[7:0];

    function isLocked;
        input [AW-1:0] a;
        begin
            isLocked = (a < LOCK_TOP) & ~writeProtectN;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Strobe edge detection
    wire syncMode = read_config_value[`FBC_CFG_SYNC_BIT];
    wire readCyc  = ~chipSelectN & writeEnableN & outputEnableN == 1'b0;
    wire advRise  = addr_valid_n & ~advQ;
    wire writeOn  = ~chipSelectN & ~writeEnableN & outputEnableN;
    // First rising edge of WE or CE ends the write
    wire wrEnd    = (~weQ & ~ceQ) & (writeEnableN | chipSelectN);
    wire clearCmd = wrEnd & outputEnableN & (pend == P_IDLE)
                    & (cmd == `FBC_CMD_CLEAR_STAT);
    wire [7:0] status = {~busy, eraseSusp, eraseErr, progErr,
                         vppErr, progSusp, protectErr, 1'b0};

    always @(posedge clock) begin
        if (inReset) begin
            ceQ  <= 1'b1;
            weQ  <= 1'b1;
            advQ <= 1'b1;
        end else begin
            ceQ  <= chipSelectN;
            weQ  <= writeEnableN;
            advQ <= addr_valid_n;
        end
    end

    // Open while ADV and CE are both low; sync mode also pulses captured on each clock edge while open
    fbc_addr_latch #(
        .AW (AW)
    ) uLatch (
        .clock     (clock),
        .srst      (inReset),
        .latchOpen (~addr_valid_n & ~chipSelectN),
        .closeNow  (syncMode),
        .addrIn    (address),
        .addrOut   (latchedAddr),
        .captured  (addrCaptured)
    );

    // Abort on reset: engine held in reset with the pin
    fbc_write_engine #(
        .ERASE_CYCLES (ERASE_CYCLES),
        .PROG_CYCLES  (PROG_CYCLES)
    ) uEngine (
        .clock       (clock),
        .srst        (inReset),
        .startErase  (startErase),
        .startProg   (startProg),
        .clearErr    (clearCmd),
        .suspendReq  (suspendReq),
        .resumeReq   (resumeReq),
        .lockedBlock (isLocked(wrAddr)),
        .vppLow      (vppLow),
        .busy        (busy),
        .eraseSusp   (eraseSusp),
        .progSusp    (progSusp),
        .eraseErr    (eraseErr),
        .progErr     (progErr),
        .vppErr      (vppErr),
        .protectErr  (protectErr)
    );

    ////////////////////////////////////////////////////////////////////
    // Command decoder; clock edges are only used to sample strobes
    always @(posedge clock) begin
        if (inReset) begin
            readMode          <= M_ARRAY;
            pend              <= P_IDLE;
            read_config_value <= `FBC_CFG_RESET;
            wrAddr            <= {AW{1'b0}};
            startErase        <= 1'b0;
            startProg         <= 1'b0;
            suspendReq        <= 1'b0;
            resumeReq         <= 1'b0;
            progStrobe        <= 1'b0;
            eraseStrobe       <= 1'b0;
            program_address   <= {AW{1'b0}};
            program_data      <= {DW{1'b0}};
        end else begin
            startErase  <= 1'b0;
            startProg   <= 1'b0;
            suspendReq  <= 1'b0;
            resumeReq   <= 1'b0;
            progStrobe  <= 1'b0;
            eraseStrobe <= 1'b0;
            if (writeOn) begin
                wrAddr <= address;
            end
            if (wrEnd && outputEnableN) begin
                case (pend)
                P_ERASE: begin
                    pend     <= P_IDLE;
                    readMode <= M_STATUS;
                    if (cmd == `FBC_CMD_CONFIRM) begin
                        startErase  <= 1'b1;
                        eraseStrobe <= ~busy & ~isLocked(wrAddr) & ~vppLow;
                    end else begin
                        startErase <= 1'b1;
                        startProg  <= 1'b1;
                    end
                end
                P_PROG: begin
                    pend            <= P_IDLE;
                    readMode        <= M_STATUS;
                    startProg       <= 1'b1;
                    progStrobe      <= ~busy & ~isLocked(wrAddr) & ~vppLow;
                    program_address <= wrAddr;
                    program_data    <= dataLinesIn;
                end
                P_CFG: begin
                    pend <= P_IDLE;
                    if (cmd == `FBC_CMD_CONFIG_CONF) begin
                        read_config_value <= wrAddr[5:0];
                    end
                end
                default: begin
                    pend <= P_IDLE;
                    case (cmd)
                    `FBC_CMD_READ_ARRAY: begin
                        if (!busy) begin
                            readMode <= M_ARRAY;
                        end
                    end
                    `FBC_CMD_READ_ID:     readMode <= M_ID;
                    `FBC_CMD_READ_STATUS: readMode <= M_STATUS;
                    `FBC_CMD_CLEAR_STAT: begin
                        readMode <= M_ARRAY;
                    end
                    `FBC_CMD_ERASE_SETUP: pend <= P_ERASE;
                    `FBC_CMD_PROG_SETUP:  pend <= P_PROG;
                    `FBC_CMD_PROG_ALT:    pend <= P_PROG;
                    `FBC_CMD_CONFIG_SET:  pend <= P_CFG;
                    `FBC_CMD_SUSPEND: begin
                        suspendReq <= 1'b1;
                        readMode   <= M_STATUS;
                    end
                    `FBC_CMD_CONFIRM: begin
                        resumeReq <= 1'b1;
                        readMode  <= M_STATUS;
                    end
                    default: readMode <= readMode;
                    endcase
                end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path
    wire burstOn  = syncMode & (readMode == M_ARRAY)
                    & (latchedAddr >= PARAM_TOP);
    reg [DW-1:0] next_data;

    always @* begin
        next_data = arrayData;
        case (readMode)
        M_STATUS: next_data = {{(DW-8){1'b0}}, status_read_data};
        M_ID: begin
            case (latchedAddr[1:0])
            `FBC_ID_MFR_ADDR: next_data = MFR_CODE;
            `FBC_ID_DEV_ADDR: next_data = DEV_CODE;
            `FBC_ID_CFG_ADDR: next_data = {{(DW-6){1'b0}},
                                           read_config_value};
            default:          next_data = {DW{1'b0}};
            endcase
        end
        default: next_data = arrayData;
        endcase
    end

    always @(posedge clock) begin
        if (inReset) begin
            data_lines       <= {DW{1'b0}};
            dataLinesOe      <= 1'b0;
            arrayAddr        <= {AW{1'b0}};
            burstAddr        <= {AW{1'b0}};
            status_read_data <= `FBC_STATUS_RESET;
        end else begin
            // Status is snapshotted at each read start
            if (clearCmd) begin
                status_read_data <= {status[7:6], 3'b000,
                                     status[2], 2'b00};
            end else if (advRise || (~outputEnableN & ceQ)) begin
                status_read_data <= status;
            end
            dataLinesOe <= readCyc & ~chipSelectN;
            data_lines  <= next_data;
            if (addrCaptured) begin
                burstAddr <= latchedAddr;
            end else if (burstOn && readCyc && addr_valid_n) begin
                // Wrap within a fixed 8-word burst on burstAddr[2:0]; config length bits unused
                burstAddr[`FBC_PAGE_BITS:0] <=
                    burstAddr[`FBC_PAGE_BITS:0] + 3'h1;
            end
            if (burstOn) begin
                arrayAddr <= burstAddr;
            end else begin
                // Page word selected by low address bits
                arrayAddr <= latchedAddr;
            end
        end
    end
endmodule

// >>> verif/fbc_cmd_sva.sv
// Checker of output float, reset and strobe behaviour
`timescale 1ns/1ps
module fbc_cmd_sva (
    // Clock and reset
    input wire       clock,
    input wire       srst,
    // Bus strobes
    input wire       powerdown_reset_n,
    input wire       chipSelectN,
    input wire       outputEnableN,
    input wire       writeEnableN,
    // Watched outputs
    input wire       dataLinesOe,
    input wire       progStrobe,
    input wire       eraseStrobe,
    input wire [7:0] status_read_data
);
    property p_oeFloat; @(posedge clock) disable iff (srst)
        outputEnableN |=> !dataLinesOe; endproperty
    a_oeFloat:
        assert property (p_oeFloat) else $error("drive with oe high");
    property p_csFloat; @(posedge clock) disable iff (srst)
        chipSelectN |=> !dataLinesOe; endproperty
    a_csFloat:
        assert property (p_csFloat) else $error("drive while deselected");
    property p_rstFloat; @(posedge clock) disable iff (srst)
        !powerdown_reset_n [*2] |-> !dataLinesOe; endproperty
    a_rstFloat:
        assert property (p_rstFloat) else $error("drive in reset");
    property p_rstStatus; @(posedge clock) disable iff (srst)
        !powerdown_reset_n |=> status_read_data == 8'h80; endproperty
    a_rstStatus:
        assert property (p_rstStatus) else $error("status not 80 at pin");
    property p_srstStatus; @(posedge clock) disable iff (!powerdown_reset_n)
        srst |=> status_read_data == 8'h80; endproperty
    a_srstStatus:
        assert property (p_srstStatus) else $error("status not 80");
    property p_enableRead; @(posedge clock)
        disable iff (srst || !powerdown_reset_n)
        (!chipSelectN && !outputEnableN && writeEnableN) |=> dataLinesOe;
    endproperty
    a_enableRead:
        assert property (p_enableRead) else $error("read not driven");
    property p_roseOe; @(posedge clock) disable iff (srst)
        $rose(dataLinesOe) |-> $past(!outputEnableN && !chipSelectN);
    endproperty
    a_roseOe:
        assert property (p_roseOe) else $error("drive without read");
    property p_progPulse; @(posedge clock) disable iff (srst)
        progStrobe |=> !progStrobe; endproperty
    a_progPulse:
        assert property (p_progPulse) else $error("program strobe long");
    property p_erasePulse; @(posedge clock) disable iff (srst)
        eraseStrobe |=> !eraseStrobe; endproperty
    a_erasePulse:
        assert property (p_erasePulse) else $error("erase strobe long");
    property p_noStrobeRst; @(posedge clock) disable iff (srst)
        !powerdown_reset_n |=> !progStrobe && !eraseStrobe; endproperty
    a_noStrobeRst:
        assert property (p_noStrobeRst) else $error("strobe in reset");
endmodule
bind fbc_command_decoder fbc_cmd_sva i_sva (.clock(clock), .srst(srst),
    .powerdown_reset_n(powerdown_reset_n), .chipSelectN(chipSelectN),
    .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
    .dataLinesOe(dataLinesOe), .progStrobe(progStrobe),
    .eraseStrobe(eraseStrobe), .status_read_data(status_read_data));

// >>> verif/fbc_store_model.sv
// Storage array model answering the decoder's array address
`timescale 1ns/1ps
module fbc_store_model (
    // Array side
    input  wire [19:0] arrayAddr,
    output wire [15:0] arrayData
);
    // Pattern differs for every word of a page
    assign arrayData = arrayAddr[15:0] ^ arrayAddr[19:4] ^ 16'hC3A5;
endmodule

// >>> verif/fbc_command_decoder_tb.sv
// Testbench of the flash bus command interface
`timescale 1ns/1ps
module fbc_command_decoder_tb;
    reg         clock = 0, srst = 1, rstPinN = 1, chipSelectN = 1;
    reg         addr_valid_n = 1, outputEnableN = 1, writeEnableN = 1;
    reg         writeProtectN = 1, vppLow = 0;
    reg  [19:0] address = 0, a, gotPa;
    reg  [15:0] dataLinesIn = 0, d, w, gotPd;
    wire [15:0] data_lines, arrayData, program_data;
    wire [19:0] arrayAddr, program_address;
    wire [7:0]  status_read_data;
    wire        dataLinesOe, progStrobe, eraseStrobe;
    reg  [31:0] seed = 32'h7d25_0a25;
    integer     miscompares = 0, cmpCount = 0, cycles = 0, i;
    integer     progCnt = 0, eraseCnt = 0, n, k;
    fbc_command_decoder #(.ERASE_CYCLES(40), .PROG_CYCLES(4),
        .MFR_CODE(16'h1234), .DEV_CODE(16'h4321)) i_dut (
        .clock(clock), .srst(srst), .powerdown_reset_n(rstPinN),
        .chipSelectN(chipSelectN), .addr_valid_n(addr_valid_n),
        .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
        .writeProtectN(writeProtectN), .vppLow(vppLow), .address(address),
        .dataLinesIn(dataLinesIn), .data_lines(data_lines),
        .dataLinesOe(dataLinesOe), .arrayData(arrayData),
        .arrayAddr(arrayAddr), .progStrobe(progStrobe),
        .program_address(program_address), .program_data(program_data),
        .eraseStrobe(eraseStrobe), .status_read_data(status_read_data));
    fbc_store_model i_store (.arrayAddr(arrayAddr), .arrayData(arrayData));
    always #4 clock = ~clock;
    ////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (progStrobe === 1'b1) begin
            progCnt <= progCnt + 1;
            gotPa <= program_address;
            gotPd <= program_data;
        end
        if (eraseStrobe === 1'b1) eraseCnt <= eraseCnt + 1;
        if (cycles == 30000) begin
            miscompares = miscompares + 1;
            summarize;
        end
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    function [15:0] store(input [19:0] x);
        store = x[15:0] ^ x[19:4] ^ 16'hC3A5;
    endfunction
    task chk(input [15:0] got, input [15:0] exp);
        begin
            cmpCount = cmpCount + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t got %h expected %h",
                    $time, got, exp);
            end
        end
    endtask
    task wr(input [19:0] x, input [15:0] v);
        begin
            address = x;
            dataLinesIn = v;
            chipSelectN = 0;
            addr_valid_n = 0;
            writeEnableN = 0;
            @(posedge clock) #1;
            addr_valid_n = 1;
            writeEnableN = 1;
            chipSelectN = 1;
            @(posedge clock) #1;
            dataLinesIn = ~v;
            address = ~x;
            @(posedge clock) #1;
        end
    endtask
    task rd(input [19:0] x, output [15:0] v);
        begin
            address = x;
            chipSelectN = 0;
            addr_valid_n = 0;
            outputEnableN = 0;
            @(posedge clock) #1 addr_valid_n = 1;
            repeat (3) @(posedge clock) #1;
            v = data_lines;
            chk({15'h0000, dataLinesOe}, 16'h0001);
            chipSelectN = 1;
            outputEnableN = 1;
            address = ~x;
            @(posedge clock) #1;
        end
    endtask
    task waitRdy(output [15:0] v);
        begin
            v = 0;
            for (k = 0; k < 60 && v[7] !== 1'b1; k = k + 1) rd(0, v);
            chk({15'h0000, v[7]}, 16'h0001);
        end
    endtask
    task burst(input [19:0] x);
        begin
            address = x;
            chipSelectN = 0;
            addr_valid_n = 0;
            outputEnableN = 0;
            @(posedge clock) #1 addr_valid_n = 1;
            repeat (3) @(posedge clock) #1;
            for (k = 0; k < 6; k = k + 1) begin
                chk(data_lines, store({x[19:3], x[2:0] + k[2:0]}));
                @(posedge clock) #1;
            end
            chipSelectN = 1;
            outputEnableN = 1;
            address = ~x;
            @(posedge clock) #1;
        end
    endtask
    task rdArray;
        begin
            seed = xs(seed);
            rd(seed[19:0], d);
            chk(d, store(seed[19:0]));
        end
    endtask
    task summarize;
        begin
            $display("compares %0d mismatches %0d", cmpCount, miscompares);
            if (miscompares == 0 && cmpCount > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clock) #1;
        srst = 0;
        @(posedge clock) #1;
        seed = xs(seed);
        for (i = 0; i < 4; i = i + 1) begin
            a = {seed[19:2], i[1:0]};
            rd(a, d);
            chk(d, store(a));
        end
        wr(0, 16'h0070);
        rd(20'h0_0003, d);
        chk(d, 16'h0080);
        wr(0, 16'h0060);
        wr(20'h0_0015, 16'h0003);
        wr(0, 16'h0090);
        rd(0, d);
        chk(d, 16'h1234);
        rd(1, d);
        chk(d, 16'h4321);
        rd(2, d);
        chk(d, 16'h0015);
        wr(0, 16'h00FF);
        rdArray;
        wr(0, 16'h0060);
        wr(20'h0_0020, 16'h0003);
        seed = xs(seed);
        burst({1'b1, seed[18:0]});
        for (i = 0; i < 2; i = i + 1) begin
            seed = xs(seed);
            a = {1'b1, seed[18:0]};
            w = seed[31:16];
            n = progCnt;
            wr(0, i ? 16'h0010 : 16'h0040);
            wr(a, w);
            waitRdy(d);
            chk(progCnt - n, 1);
            chk(gotPa[15:0], a[15:0]);
            chk(gotPa[19:4], a[19:4]);
            chk(gotPd, w);
            chk(d, 16'h0080);
        end
        n = eraseCnt;
        wr(0, 16'h0020);
        wr(20'h9_1000, 16'h00D0);
        wr(0, 16'h00FF);
        rd(20'h9_1000, d);
        chk({15'h0000, d[7]}, 0);
        wr(0, 16'h00B0);
        waitRdy(d);
        chk({15'h0000, d[6]}, 1);
        wr(0, 16'h00D0);
        waitRdy(d);
        chk(d, 16'h0080);
        chk(eraseCnt - n, 1);
        writeProtectN = 0;
        wr(0, 16'h0040);
        wr(20'h0_0100, 16'h5A5A);
        waitRdy(d);
        wr(0, 16'h0020);
        wr(0, 16'h0040);
        waitRdy(d);
        chk({d[5:4], d[1]}, 16'h0007);
        writeProtectN = 1;
        vppLow = 1;
        n = progCnt;
        wr(0, 16'h0010);
        wr(20'h8_0000, 16'h0001);
        waitRdy(d);
        chk(d[3], 1);
        chk(progCnt - n, 0);
        vppLow = 0;
        wr(0, 16'h0050);
        rdArray;
        wr(0, 16'h0070);
        rd(0, d);
        chk(d, 16'h0080);
        wr(0, 16'h0020);
        wr(20'h9_1000, 16'h00D0);
        rstPinN = 0;
        repeat (2) @(posedge clock) #1;
        rstPinN = 1;
        @(posedge clock) #1;
        rdArray;
        wr(0, 16'h0070);
        rd(0, d);
        chk(d, 16'h0080);
        wr(0, 16'h0090);
        rd(2, d);
        chk(d, 16'h0000);
        summarize;
    end
endmodule
